// ==== design/cmrm_core.sv ====
// mode control and register map of one can controller, ahb slave front end
`include "cmrm_defines.svh"
module cmrm_core (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // ahb slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // received bytes from the bit engine
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_frame_end,
  // transmit completion from the bit engine
  input  wire logic        tx_done,
  // configuration and transmit request/abort pulses towards the bit engine
  output logic             bus_enable,
  output logic             extended_register_model,
  output logic [7:0]       acc_code,
  output logic [7:0]       acc_mask,
  output logic [7:0]       bit_timing0,
  output logic [7:0]       bit_timing1,
  output logic             tx_request,
  output logic             tx_abort
);
  // one word per byte register: byte address is index times four
  typedef struct packed {
    logic                 wr_pend;
    logic [4:0]           wr_idx;
    cmrm_pkg::cmrm_mode_t mode;
    logic [7:0]           control;
    logic [7:0]           clkdiv;
    logic [7:0]           acode;
    logic [7:0]           amask;
    logic [7:0]           btr0;
    logic [7:0]           btr1;
    logic                 rx_full;
    logic                 overrun;
    logic                 tx_busy;
    logic                 tx_complete;
    logic                 rx_int;
    logic                 tx_int;
    logic                 ovr_int;
    logic                 tx_req;
    logic                 tx_abt;
    logic [31:0]          rdata;
  } cmrm_core_st_t;

  cmrm_core_st_t r_r, r_nxt;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       fifo_in_ready;
  logic       rd_take, wr_take, fifo_pop, fifo_clear;
  logic [4:0] req_idx;
  logic [7:0] wbyte;

  // true for registers hidden while operating
  function automatic logic cmrm_cfg_only(input logic [4:0] idx);
    return idx >= `CMRM_OFS_ACC_CODE && idx <= `CMRM_OFS_BIT_TIME1;
  endfunction

  function automatic logic [7:0] cmrm_status(input cmrm_core_st_t s);
    logic [7:0] v;
    v = `CMRM_ZERO_BYTE;
    v[`CMRM_STAT_RBS_BIT]  = s.rx_full;
    v[`CMRM_STAT_DOS_BIT]  = s.overrun;
    v[`CMRM_STAT_TBS_BIT]  = !s.tx_busy;
    v[`CMRM_STAT_TCS_BIT]  = s.tx_complete;
    v[`CMRM_STAT_MODE_BIT] = (s.mode == cmrm_pkg::cmrm_config);
    return v;
  endfunction

  assign req_idx   = haddr[6:2];
  assign rd_take   = hsel && hready && htrans == `CMRM_HTRANS_NONSEQ && !hwrite;
  assign wr_take   = hsel && hready && htrans == `CMRM_HTRANS_NONSEQ && hwrite;
  assign wbyte     = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = `CMRM_HRESP_OKAY;
  assign hrdata    = r_r.rdata;

  // a frame in the fifo is presented byte by byte as the receive buffer
  assign fifo_clear = (r_r.mode == cmrm_pkg::cmrm_config);
  assign fifo_pop   = rd_take && req_idx == `CMRM_OFS_RX_BUF && fifo_out_valid;
  assign rx_ready   = fifo_in_ready && r_r.mode == cmrm_pkg::cmrm_operate;

  always_comb begin
    r_nxt = r_r;
    r_nxt.tx_req  = 1'b0;
    r_nxt.tx_abt  = 1'b0;
    r_nxt.wr_pend = wr_take;
    r_nxt.wr_idx  = req_idx;

    // events from the bit engine; a register write in the same cycle overrides them
    if (tx_done) begin
      r_nxt.tx_busy     = 1'b0;
      r_nxt.tx_complete = 1'b1;
    end

    // ahb data phase of a write
    if (r_r.wr_pend) begin
      unique case (r_r.wr_idx)
        `CMRM_OFS_CONTROL: begin
          r_nxt.control = (`CMRM_CTRL_RESET & ~`CMRM_CTRL_WMASK)
                        | (wbyte & `CMRM_CTRL_WMASK);
          r_nxt.mode = wbyte[`CMRM_CTRL_RR_BIT] ? cmrm_pkg::cmrm_config
                                                : cmrm_pkg::cmrm_operate;
        end
        `CMRM_OFS_COMMAND: begin
          if (r_r.mode == cmrm_pkg::cmrm_operate) begin
            if (wbyte[`CMRM_CMD_TR_BIT] && !r_r.tx_busy) begin
              r_nxt.tx_req      = 1'b1;
              r_nxt.tx_busy     = 1'b1;
              r_nxt.tx_complete = 1'b0;
            end
            r_nxt.tx_abt = wbyte[`CMRM_CMD_AT_BIT];
          end
          if (wbyte[`CMRM_CMD_CDO_BIT]) r_nxt.overrun = 1'b0;
          if (wbyte[`CMRM_CMD_RRB_BIT]) r_nxt.rx_full = 1'b0;
        end
        `CMRM_OFS_ACC_CODE: if (r_r.mode == cmrm_pkg::cmrm_config) r_nxt.acode = wbyte;
        `CMRM_OFS_ACC_MASK: if (r_r.mode == cmrm_pkg::cmrm_config) r_nxt.amask = wbyte;
        `CMRM_OFS_BIT_TIME0: if (r_r.mode == cmrm_pkg::cmrm_config) r_nxt.btr0 = wbyte;
        `CMRM_OFS_BIT_TIME1: if (r_r.mode == cmrm_pkg::cmrm_config) r_nxt.btr1 = wbyte;
        `CMRM_OFS_CLKDIV: r_nxt.clkdiv = wbyte;
        default: ;
      endcase
      if (r_r.wr_idx == `CMRM_OFS_CONTROL && wbyte[`CMRM_CTRL_RR_BIT]) begin
        r_nxt.tx_busy = 1'b0;
        r_nxt.tx_abt  = 1'b1;
      end
    end

    // receive events set after clears so a same-cycle event is kept
    if (rx_frame_end && r_r.mode == cmrm_pkg::cmrm_operate) begin
      if (r_r.rx_full) r_nxt.overrun = 1'b1;
      r_nxt.rx_full = 1'b1;
    end
    if (rx_valid && !fifo_in_ready && r_r.mode == cmrm_pkg::cmrm_operate)
      r_nxt.overrun = 1'b1;

    // interrupt flags follow enabled events and clear on read
    if (rd_take && req_idx == `CMRM_OFS_INTR) begin
      r_nxt.rx_int  = 1'b0;
      r_nxt.tx_int  = 1'b0;
      r_nxt.ovr_int = 1'b0;
    end
    if (rx_frame_end && r_r.control[`CMRM_CTRL_RIE_BIT]) r_nxt.rx_int = 1'b1;
    if (tx_done && r_r.control[`CMRM_CTRL_TIE_BIT])      r_nxt.tx_int = 1'b1;
    if (r_nxt.overrun && !r_r.overrun && r_r.control[`CMRM_CTRL_OIE_BIT])
      r_nxt.ovr_int = 1'b1;

    // read data is registered for the data phase
    if (rd_take) begin
      unique case (req_idx)
        `CMRM_OFS_CONTROL:  r_nxt.rdata = {24'h000000, r_r.control};
        `CMRM_OFS_COMMAND:  r_nxt.rdata = {24'h000000, `CMRM_ALL_ONES};
        `CMRM_OFS_STATUS:   r_nxt.rdata = {24'h000000, cmrm_status(r_r)};
        `CMRM_OFS_INTR: begin
          r_nxt.rdata = {24'h000000, `CMRM_ZERO_BYTE};
          r_nxt.rdata[`CMRM_INT_RI_BIT]  = r_r.rx_int;
          r_nxt.rdata[`CMRM_INT_TI_BIT]  = r_r.tx_int;
          r_nxt.rdata[`CMRM_INT_DOI_BIT] = r_r.ovr_int;
        end
        `CMRM_OFS_CLKDIV:   r_nxt.rdata = {24'h000000, r_r.clkdiv};
        default:            r_nxt.rdata = {24'h000000, `CMRM_ZERO_BYTE};
      endcase
      if (cmrm_cfg_only(req_idx)) begin
        if (r_r.mode == cmrm_pkg::cmrm_operate) begin
          r_nxt.rdata = {24'h000000, `CMRM_ALL_ONES};
        end else begin
          unique case (req_idx)
            `CMRM_OFS_ACC_CODE:  r_nxt.rdata = {24'h000000, r_r.acode};
            `CMRM_OFS_ACC_MASK:  r_nxt.rdata = {24'h000000, r_r.amask};
            `CMRM_OFS_BIT_TIME0: r_nxt.rdata = {24'h000000, r_r.btr0};
            default:             r_nxt.rdata = {24'h000000, r_r.btr1};
          endcase
        end
      end
      if (req_idx == `CMRM_OFS_RX_BUF)
        r_nxt.rdata = {24'h000000, fifo_out_valid ? fifo_out_data : `CMRM_ZERO_BYTE};
    end

    if (r_nxt.mode == cmrm_pkg::cmrm_config) begin
      r_nxt.rx_full = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_r         <= '0;
      r_r.mode    <= cmrm_pkg::cmrm_config;
      r_r.control <= `CMRM_CTRL_RESET;
      r_r.tx_complete <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  cmrm_fifo #(
    .WIDTH (`CMRM_FIFO_WIDTH),
    .DEPTH (`CMRM_FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .clear     (fifo_clear),
    .in_valid  (rx_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // bit engine stays off the bus in configuration mode
  assign bus_enable              = (r_r.mode == cmrm_pkg::cmrm_operate);
  assign extended_register_model = r_r.clkdiv[`CMRM_CDR_MODEL_BIT];
  assign acc_code                = r_r.acode;
  assign acc_mask                = r_r.amask;
  // bit timing passes through; at 100 MHz a 1 Mb/s bit is 100 cycles, ample headroom
  assign bit_timing0             = r_r.btr0;
  assign bit_timing1             = r_r.btr1;
  assign tx_request              = r_r.tx_req;
  assign tx_abort                = r_r.tx_abt;
endmodule

// ==== design/cmrm_defines.svh ====
// register offsets, field positions, reset values and timing constants for the can mode front end
`ifndef CMRM_DEFINES_SVH
`define CMRM_DEFINES_SVH
`define CMRM_OFS_CONTROL      5'h00
`define CMRM_OFS_COMMAND      5'h01
`define CMRM_OFS_STATUS       5'h02
`define CMRM_OFS_INTR         5'h03
`define CMRM_OFS_ACC_CODE     5'h04
`define CMRM_OFS_ACC_MASK     5'h05
`define CMRM_OFS_BIT_TIME0    5'h06
`define CMRM_OFS_BIT_TIME1    5'h07
`define CMRM_OFS_CLKDIV       5'h1F
`define CMRM_CTRL_RESET       8'h21
`define CMRM_CTRL_WMASK       8'h1F
`define CMRM_CTRL_RR_BIT      0
`define CMRM_CTRL_RIE_BIT     1
`define CMRM_CTRL_TIE_BIT     2
`define CMRM_CTRL_OIE_BIT     4
`define CMRM_OFS_RX_BUF       5'h14
`define CMRM_CDR_MODEL_BIT    7
`define CMRM_CMD_TR_BIT       0
`define CMRM_CMD_AT_BIT       1
`define CMRM_CMD_RRB_BIT      2
`define CMRM_CMD_CDO_BIT      3
`define CMRM_ALL_ONES         8'hFF
`define CMRM_ZERO_BYTE        8'h00
`define CMRM_STAT_RBS_BIT     0
`define CMRM_STAT_DOS_BIT     1
`define CMRM_STAT_TBS_BIT     2
`define CMRM_STAT_TCS_BIT     3
`define CMRM_STAT_MODE_BIT    4
`define CMRM_INT_RI_BIT       0
`define CMRM_INT_TI_BIT       1
`define CMRM_INT_DOI_BIT      3
`define CMRM_CLK_MHZ          100
`define CMRM_MAX_KBPS         1000
`define CMRM_MIN_BIT_CYCLES   ((`CMRM_CLK_MHZ * 1000) / `CMRM_MAX_KBPS)
`define CMRM_FIFO_WIDTH       8
`define CMRM_FIFO_DEPTH       32
`define CMRM_HTRANS_NONSEQ    2'b10
`define CMRM_HRESP_OKAY       1'b0
`endif

// ==== design/cmrm_pkg.sv ====
// shared types of the can mode front end
package cmrm_pkg;
  typedef enum logic {cmrm_config, cmrm_operate} cmrm_mode_t;
endpackage

// ==== design/cmrm_fifo.sv ====
// parameterised valid/ready fifo for the receive byte stream
`include "cmrm_defines.svh"
module cmrm_fifo #(
  parameter int WIDTH = `CMRM_FIFO_WIDTH,
  parameter int DEPTH = `CMRM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // flush
  input  wire logic             clear,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } cmrm_fifo_st_t;
  cmrm_fifo_st_t st_r, st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push, pop;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = mem_r[st_r.rp];
  assign push      = in_valid && in_ready && !clear;
  assign pop       = out_valid && out_ready && !clear;

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt = '0;
    end else begin
      if (push) st_nxt.wp = st_r.wp + 1'b1;
      if (pop)  st_nxt.rp = st_r.rp + 1'b1;
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) st_r <= '0;
    else       st_r <= st_nxt;
  end

  // storage needs no reset; it is only read behind a valid count
  always_ff @(posedge mclk) begin
    if (push) mem_r[st_r.wp] <= in_data;
  end
endmodule

// ==== testbench/cmrm_asserts.sv ====
// concurrent checks on the can mode front end ports
module cmrm_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // ahb slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // engine side
  input wire logic        rx_ready,
  input wire logic        bus_enable,
  input wire logic        extended_register_model,
  input wire logic [7:0]  acc_code,
  input wire logic [7:0]  acc_mask,
  input wire logic [7:0]  bit_timing0,
  input wire logic [7:0]  bit_timing1,
  input wire logic        tx_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic take;
  logic wr_ctl_r;
  logic wr_cdr_r;
  logic rd_ones_r;
  assign take = hsel & hready & (htrans == 2'h2);
  // data phase flags, decided on the address phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ctl_r <= 1'h0;
      wr_cdr_r <= 1'h0;
      rd_ones_r <= 1'h0;
    end else begin
      wr_ctl_r <= take & hwrite & (haddr[7:0] == 8'h00);
      wr_cdr_r <= take & hwrite & (haddr[7:0] == 8'h7C);
      rd_ones_r <= take & !hwrite & ((haddr[7:0] == 8'h04) | (bus_enable & (haddr[7:4] == 4'h1)));
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_reset_config: assert property ($rose(nrst) |-> !bus_enable && !rx_ready)
    else $error("not in configuration after reset");
  a_leave_config: assert property ($rose(bus_enable) |-> $past(wr_ctl_r))
    else $error("operating mode without control write");
  a_mode_follow: assert property (wr_ctl_r |=> bus_enable == !$past(hwdata[0]))
    else $error("mode does not follow reset request");
  a_model_select: assert property (wr_cdr_r |=> extended_register_model == $past(hwdata[7]))
    else $error("register model does not follow divider bit");
  a_locked_regs: assert property (bus_enable && $past(bus_enable) |->
    $stable({acc_code, acc_mask, bit_timing0, bit_timing1}))
    else $error("config register changed while operating");
  a_ones_read: assert property (rd_ones_r |-> hrdata == 32'h000000FF)
    else $error("read of hidden register not all ones");
  a_rx_gated: assert property (rx_ready |-> bus_enable)
    else $error("receive accepted in configuration");
  a_tx_pulse: assert property (tx_request |-> $past(bus_enable) ##1 !tx_request)
    else $error("transmit request malformed");
endmodule

bind cmrm_core cmrm_checker cmrm_checker_inst (.*);

// ==== testbench/cmrm_engine_model.sv ====
// bit engine stand-in: byte stream source and transmit completion
module cmrm_engine_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // bench control
  input  wire logic       stream_en,
  input  wire logic [3:0] tx_delay,
  // core side
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_request,
  output logic            tx_done,
  output logic [7:0]      sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  assign rx_valid = stream_en;
  // idle data inverted so a stale byte is never mistaken for a fresh one
  assign rx_data = rx_valid ? 8'hA0 + sent : ~(8'hA0 + sent);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sent <= 8'h00;
      wait_r <= 4'h0;
      tx_done <= 1'h0;
    end else begin
      if (rx_valid && rx_ready) sent <= sent + 8'h01;
      tx_done <= (wait_r == 4'h1);
      if (tx_request) wait_r <= tx_delay;
      else if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    end
  end
endmodule

// ==== testbench/tb_can_mode_and_register_map.sv ====
// self-checking bench for the can mode front end
module tb_can_mode_and_register_map;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, hsel, hwrite, stream_en, hreadyout, hresp, rx_valid, rx_ready;
  logic tx_done, bus_enable, ext_model, tx_request, frame_end, tx_abort;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [7:0] rx_data, acc_code, acc_mask, bt0, bt1, sent, v;
  logic [7:0] cfg [4];
  logic [3:0] tx_delay;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  int seed = 32'h29e18f87;
  cmrm_core cmrm_core_inst (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h0), .hwdata(hwdata), .hready(1'h1),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_frame_end(frame_end), .tx_done(tx_done),
    .bus_enable(bus_enable), .extended_register_model(ext_model), .acc_code(acc_code),
    .acc_mask(acc_mask), .bit_timing0(bt0), .bit_timing1(bt1), .tx_request(tx_request),
    .tx_abort(tx_abort));
  cmrm_engine_model cmrm_engine_model_inst (.mclk(mclk), .nrst(nrst), .stream_en(stream_en),
    .tx_delay(tx_delay), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_request(tx_request), .tx_done(tx_done), .sent(sent));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // expected status byte from its flags
  function automatic logic [31:0] status_exp(input logic rxf, input logic ovr,
    input logic tfree, input logic tdone, input logic cfgm);
    return {27'h0, cfgm, tdone, tfree, ovr, rxf};
  endfunction
  // address phase, then data phase with the bus idle; two edges in all
  task automatic wr(input logic [4:0] ofs, input logic [7:0] d);
    hsel = 1'h1;
    htrans = 2'h2;
    hwrite = 1'h1;
    haddr = {25'h0, ofs, 2'h0};
    @(negedge mclk);
    hsel = 1'h0;
    htrans = 2'h0;
    hwdata = {24'h0, d};
    @(negedge mclk);
  endtask
  task automatic rd(input logic [4:0] ofs);
    hsel = 1'h1;
    htrans = 2'h2;
    hwrite = 1'h0;
    haddr = {25'h0, ofs, 2'h0};
    @(negedge mclk);
    hsel = 1'h0;
    htrans = 2'h0;
    rv = hrdata;
    @(negedge mclk);
  endtask
  initial begin
    nrst = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    stream_en = 1'h1;
    frame_end = 1'h0;
    tx_delay = 4'h8;
    repeat (12) @(negedge mclk);
    nrst = 1'h1;
    @(negedge mclk);
    check(bus_enable, 1'h0);
    rd(5'h00);
    check(rv, 32'h21);
    wr(5'h02, 8'hFF);
    rd(5'h02);
    check(rv, status_exp(1'h0, 1'h0, 1'h1, 1'h1, 1'h1));
    rd(5'h01);
    check(rv, 32'hFF);
    rd(5'h08);
    check(rv, 32'h0);
    for (i = 0; i < 4; i++) begin
      cfg[i] = 8'($random(seed));
      wr(5'h04 + i[4:0], cfg[i]);
      rd(5'h04 + i[4:0]);
      check(rv, {24'h0, cfg[i]});
    end
    check({acc_code, acc_mask, bt0, bt1}, {cfg[0], cfg[1], cfg[2], cfg[3]});
    for (i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      v[7] = i[0];
      wr(5'h1F, v);
      check(ext_model, v[7]);
      rd(5'h1F);
      check(rv, {24'h0, v});
    end
    check(sent, 8'h00);
    wr(5'h00, 8'h00);
    check(bus_enable, 1'h1);
    rd(5'h00);
    check(rv, 32'h20);
    for (i = 0; i < 4; i++) begin
      wr(5'h04 + i[4:0], ~cfg[i]);
      rd(5'h04 + i[4:0]);
      check(rv, 32'hFF);
    end
    check({acc_code, acc_mask, bt0, bt1}, {cfg[0], cfg[1], cfg[2], cfg[3]});
    wr(5'h1F, 8'h80);
    rd(5'h1F);
    check({ext_model, rv}, {1'h1, 32'h80});
    tx_delay = 4'h8 | 4'($random(seed));
    wr(5'h01, 8'h01);
    rd(5'h02);
    check(rv, status_exp(1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    repeat (20) @(negedge mclk);
    rd(5'h02);
    check(rv, status_exp(1'h0, 1'h1, 1'h1, 1'h1, 1'h0));
    check(sent, 8'h20);
    rd(5'h14);
    check(rv, 32'hA0);
    @(negedge mclk);
    check(sent, 8'h21);
    // receive interrupt enabled, one frame end, then clear-on-read
    wr(5'h00, 8'h02);
    frame_end = 1'h1;
    @(negedge mclk);
    frame_end = 1'h0;
    rd(5'h03);
    check(rv, 32'h01);
    wr(5'h03, 8'hFF);
    rd(5'h03);
    check(rv, 32'h00);
    rd(5'h02);
    check(rv, status_exp(1'h1, 1'h1, 1'h1, 1'h1, 1'h0));
    // overrun clear loses to a same-cycle overrun from the full fifo
    wr(5'h01, 8'h0C);
    rd(5'h02);
    check(rv, status_exp(1'h0, 1'h1, 1'h1, 1'h1, 1'h0));
    stream_en = 1'h0;
    wr(5'h00, 8'h01);
    check({bus_enable, rx_ready, tx_abort}, 3'h1);
    rd(5'h04);
    check(rv, {24'h0, cfg[0]});
    // reset in mid-run returns everything to configuration
    nrst = 1'h0;
    repeat (2) @(negedge mclk);
    check({bus_enable, tx_abort}, 2'h0);
    nrst = 1'h1;
    @(negedge mclk);
    rd(5'h00);
    check(rv, 32'h21);
    rd(5'h04);
    check({ext_model, rv}, 33'h0);
    close_out();
  end
endmodule
